// [mdio_pkg.sv]
// constants, types and helpers shared by the digital i/o block
package mdio_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned BP_PULSE_NS = 90;
	// least time, so round up: 5 cycles = 100 ns, inside the 90..120 ns window
	localparam int unsigned BP_PULSE_CYC = (BP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_PORT0 = 8'h00;
	localparam logic [7:0] OFF_PORT1 = 8'h04;
	localparam logic [7:0] OFF_PORT2 = 8'h08;
	localparam logic [7:0] OFF_PORT3 = 8'h0c;
	localparam logic [7:0] OFF_DIR = 8'h10;
	localparam logic [7:0] OFF_POL = 8'h14;
	localparam logic [7:0] OFF_PWM_CTRL = 8'h18;
	localparam logic [7:0] OFF_PULSE_OUTPUT_ONE = 8'h1c;
	localparam logic [7:0] OFF_PULSE_OUTPUT_TWO = 8'h20;
	localparam logic [7:0] OFF_TBUS_ROUTE = 8'h24;
	localparam logic [7:0] OFF_TBUS_GPIO = 8'h28;
	localparam logic [7:0] OFF_TBUS_IN = 8'h2c;
	localparam logic [7:0] OFF_FILT = 8'h30;
	localparam logic [7:0] OFF_BP_POS = 8'h34;
	localparam logic [7:0] OFF_BP_CTRL = 8'h38;
	localparam logic [7:0] OFF_CAP_CTRL = 8'h3c;
	localparam logic [7:0] OFF_STATUS = 8'h40;
	localparam logic [7:0] OFF_ENC_COUNT = 8'h44;
	localparam logic [7:0] OFF_CAP_POS = 8'h48;
	localparam logic [7:0] OFF_STRAP = 8'h4c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned PWM_EXT_CLK_BIT = 0;
	localparam int unsigned TBUS_DIR_LSB = 8;
	localparam int unsigned BP_EN_BIT = 0;
	localparam int unsigned CAP_EN_BIT = 0;
	localparam int unsigned CAP_SEL_LSB = 1;
	localparam int unsigned ST_CAP_BIT = 0;
	localparam int unsigned ST_BP_BIT = 1;
	localparam int unsigned ROUTE_W = 3;

	// ----------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [31:0] DIR_RST = 32'h0000_0000;
	localparam logic [31:0] POL_RST = 32'h0000_0000;
	localparam logic [3:0] FILT_RST = 4'h0;
	localparam logic PULL_UP_RST = 1'b1;
	localparam logic [2:0] RT_GPIO = 3'h0;
	localparam logic [2:0] RT_BP = 3'h1;
	localparam logic [2:0] RT_ENC_A = 3'h2;
	localparam logic [2:0] RT_ENC_B = 3'h3;
	localparam logic [2:0] RT_INDEX = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [15:0] duty;
		logic [15:0] period;
	} mdio_pwm_cfg_t;

	// byte-lane merge for register writes
	function automatic logic [31:0] mdio_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction
endpackage

// [mdio_pwm_gen.sv]
// one pwm generator: free-running counter against period and duty
`timescale 1ns/1ns
module mdio_pwm_gen
	import mdio_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic tick_in,
	input mdio_pwm_cfg_t cfg_in,
	output logic pwm_out
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic pwm_q;
	logic pwm_d;

	always_comb begin
		cnt_d = cnt_q;
		if (tick_in) begin
			cnt_d = (cnt_q + 16'h1 >= cfg_in.period) ? 16'h0 : cnt_q + 16'h1;
		end
		// high fraction is duty over period
		pwm_d = (cnt_d < cfg_in.duty);
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_q <= 16'h0;
			pwm_q <= 1'b0;
		end else if (ce_in) begin
			cnt_q <= cnt_d;
			pwm_q <= pwm_d;
		end
	end

	assign pwm_out = pwm_q;
endmodule

// [mdio_top.sv]
// digital i/o, pwm and trigger bus routing with an axi4-lite register slave
`timescale 1ns/1ns
module mdio_top
	import mdio_pkg::*;
#(
	parameter int unsigned TBUS_W = 8
)(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] gpio_in,
	output logic [31:0] gpio_out,
	output logic [31:0] gpio_oe_out,
	input wire logic pull_select_strap_in,
	output logic pull_up_en_out,
	output logic pull_down_en_out,
	input wire logic pwm_clk_in,
	output logic pulse_output_one_out,
	output logic pulse_output_two_out,
	input wire logic enc_a_in,
	input wire logic enc_b_in,
	input wire logic enc_index_in,
	input wire logic [TBUS_W-1:0] shared_trigger_bus_in,
	output logic [TBUS_W-1:0] shared_trigger_bus_out,
	output logic [TBUS_W-1:0] shared_trigger_bus_oe_out
);
	localparam int unsigned SW = 37 + TBUS_W;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic [31:0] gpio_s;
	logic [2:0] enc_s;
	logic strap_s;
	logic pclk_s;
	logic [TBUS_W-1:0] tbus_s;

	// no reset here: the strap must already stand in the second flop when reset lifts
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			sync1_q <= {shared_trigger_bus_in, pwm_clk_in, pull_select_strap_in,
				enc_index_in, enc_b_in, enc_a_in, gpio_in};
			sync2_q <= sync1_q;
		end
	end

	assign gpio_s = sync2_q[31:0];
	assign enc_s = sync2_q[34:32];
	assign strap_s = sync2_q[35];
	assign pclk_s = sync2_q[36];
	assign tbus_s = sync2_q[SW-1:37];

	// ----------------------------------------------------------------
	// bus slave and registers
	// ----------------------------------------------------------------
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [31:0] port_out_q, port_out_d, dir_q, dir_d, pol_q, pol_d;
	logic pwm_ext_q, pwm_ext_d;
	mdio_pwm_cfg_t pulse_output_one_q, pulse_output_one_d, pulse_output_two_q, pulse_output_two_d;
	logic [31:0] route_q, route_d;
	logic [15:0] tgpio_q, tgpio_d;
	logic [3:0] filt_set_q, filt_set_d;
	logic [31:0] bp_pos_q, bp_pos_d;
	logic bp_en_q, bp_en_d;
	logic [3:0] cap_ctrl_q, cap_ctrl_d;
	logic [1:0] status_q, status_d;
	logic [1:0] st_clr;
	logic pull_up_q, pull_up_d, strap_done_q, strap_done_d;
	logic wr_go;
	logic [31:0] gpio_rd;
	logic cap_hit, bp_hit;
	logic [31:0] enc_cnt_q, cap_pos_q;

	always_comb begin
		aw_held_d = aw_held_q | (s_axi_awvalid_in & awready_q);
		w_held_d = w_held_q | (s_axi_wvalid_in & wready_q);
		awaddr_d = (s_axi_awvalid_in & awready_q) ? s_axi_awaddr_in : awaddr_q;
		wdata_d = (s_axi_wvalid_in & wready_q) ? s_axi_wdata_in : wdata_q;
		wstrb_d = (s_axi_wvalid_in & wready_q) ? s_axi_wstrb_in : wstrb_q;
		bvalid_d = bvalid_q & ~s_axi_bready_in;
		bresp_d = bresp_q;
		port_out_d = port_out_q;
		dir_d = dir_q;
		pol_d = pol_q;
		pwm_ext_d = pwm_ext_q;
		pulse_output_one_d = pulse_output_one_q;
		pulse_output_two_d = pulse_output_two_q;
		route_d = route_q;
		tgpio_d = tgpio_q;
		filt_set_d = filt_set_q;
		bp_pos_d = bp_pos_q;
		bp_en_d = bp_en_q;
		cap_ctrl_d = cap_ctrl_q;
		st_clr = 2'h0;
		wr_go = aw_held_q & w_held_q & ~bvalid_q;
		if (wr_go) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (awaddr_q)
				OFF_PORT0, OFF_PORT1, OFF_PORT2, OFF_PORT3: begin
					// whole byte lands on all eight lines at once
					if (wstrb_q[0]) begin
						port_out_d[8*awaddr_q[3:2] +: 8] = wdata_q[7:0];
					end
				end
				OFF_DIR: dir_d = mdio_merge(dir_q, wdata_q, wstrb_q);
				OFF_POL: pol_d = mdio_merge(pol_q, wdata_q, wstrb_q);
				OFF_PWM_CTRL: begin
					if (wstrb_q[0]) begin
						pwm_ext_d = wdata_q[PWM_EXT_CLK_BIT];
					end
				end
				OFF_PULSE_OUTPUT_ONE: pulse_output_one_d = mdio_merge(pulse_output_one_q, wdata_q, wstrb_q);
				OFF_PULSE_OUTPUT_TWO: pulse_output_two_d = mdio_merge(pulse_output_two_q, wdata_q, wstrb_q);
				OFF_TBUS_ROUTE: route_d = mdio_merge(route_q, wdata_q, wstrb_q);
				OFF_TBUS_GPIO: tgpio_d = 16'(mdio_merge({16'h0, tgpio_q}, wdata_q, wstrb_q));
				OFF_FILT: begin
					if (wstrb_q[0]) begin
						filt_set_d = wdata_q[3:0];
					end
				end
				OFF_BP_POS: bp_pos_d = mdio_merge(bp_pos_q, wdata_q, wstrb_q);
				OFF_BP_CTRL: begin
					if (wstrb_q[0]) begin
						bp_en_d = wdata_q[BP_EN_BIT];
					end
				end
				OFF_CAP_CTRL: begin
					if (wstrb_q[0]) begin
						cap_ctrl_d = wdata_q[3:0];
					end
				end
				OFF_STATUS: begin
					if (wstrb_q[0]) begin
						st_clr = wdata_q[1:0];
					end
				end
				OFF_TBUS_IN, OFF_ENC_COUNT, OFF_CAP_POS, OFF_STRAP: ;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		awready_d = ~aw_held_d;
		wready_d = ~w_held_d;
		// events win over a clear in the same cycle
		status_d = (status_q & ~st_clr) | {bp_hit, cap_hit};
		// strap caught once, on the first enabled cycle after reset
		strap_done_d = 1'b1;
		pull_up_d = strap_done_q ? pull_up_q : strap_s;

		// input lines read through their polarity, outputs read their latch
		gpio_rd = (gpio_s ^ pol_q) & ~dir_q | (port_out_q & dir_q);
		rvalid_d = rvalid_q & ~s_axi_rready_in;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid_in & arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0;
			unique case (s_axi_araddr_in)
				OFF_PORT0, OFF_PORT1, OFF_PORT2, OFF_PORT3: begin
					rdata_d[7:0] = gpio_rd[8*s_axi_araddr_in[3:2] +: 8];
				end
				OFF_DIR: rdata_d = dir_q;
				OFF_POL: rdata_d = pol_q;
				OFF_PWM_CTRL: rdata_d[PWM_EXT_CLK_BIT] = pwm_ext_q;
				OFF_PULSE_OUTPUT_ONE: rdata_d = pulse_output_one_q;
				OFF_PULSE_OUTPUT_TWO: rdata_d = pulse_output_two_q;
				OFF_TBUS_ROUTE: rdata_d = route_q;
				OFF_TBUS_GPIO: rdata_d[15:0] = tgpio_q;
				OFF_TBUS_IN: rdata_d[TBUS_W-1:0] = tbus_s;
				OFF_FILT: rdata_d[3:0] = filt_set_q;
				OFF_BP_POS: rdata_d = bp_pos_q;
				OFF_BP_CTRL: rdata_d[BP_EN_BIT] = bp_en_q;
				OFF_CAP_CTRL: rdata_d[3:0] = cap_ctrl_q;
				OFF_STATUS: rdata_d[1:0] = status_q;
				OFF_ENC_COUNT: rdata_d = enc_cnt_q;
				OFF_CAP_POS: rdata_d = cap_pos_q;
				OFF_STRAP: rdata_d[0] = pull_up_q;
				default: rresp_d = RESP_SLVERR;
			endcase
		end
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0;
			awaddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			port_out_q <= 32'h0;
			// every line an input after reset
			dir_q <= DIR_RST;
			pol_q <= POL_RST;
			pwm_ext_q <= 1'b0;
			pulse_output_one_q <= '0;
			pulse_output_two_q <= '0;
			route_q <= 32'h0;
			tgpio_q <= 16'h0;
			filt_set_q <= FILT_RST;
			bp_pos_q <= 32'h0;
			bp_en_q <= 1'b0;
			cap_ctrl_q <= 4'h0;
			status_q <= 2'h0;
			pull_up_q <= PULL_UP_RST;
			strap_done_q <= 1'b0;
		end else if (ce_in) begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			port_out_q <= port_out_d;
			dir_q <= dir_d;
			pol_q <= pol_d;
			pwm_ext_q <= pwm_ext_d;
			pulse_output_one_q <= pulse_output_one_d;
			pulse_output_two_q <= pulse_output_two_d;
			route_q <= route_d;
			tgpio_q <= tgpio_d;
			filt_set_q <= filt_set_d;
			bp_pos_q <= bp_pos_d;
			bp_en_q <= bp_en_d;
			cap_ctrl_q <= cap_ctrl_d;
			status_q <= status_d;
			pull_up_q <= pull_up_d;
			strap_done_q <= strap_done_d;
		end
	end

	// ----------------------------------------------------------------
	// encoder filter, counter, breakpoint and capture
	// ----------------------------------------------------------------
	logic [2:0] enc_f_q, enc_f_d, enc_o_q;
	logic [3:0] flt_cnt_q [3];
	logic [3:0] flt_cnt_d [3];
	logic [31:0] enc_cnt_d, cap_pos_d;
	logic [2:0] bp_cnt_q, bp_cnt_d;
	logic [TBUS_W-1:0] tbus_o_q, tbus_dr_d, tbus_oe_d;
	logic [TBUS_W-1:0] tbus_dr_q, tbus_oe_q;
	logic [2:0] cap_sel;
	logic moved;
	logic [2:0] rt;

	always_comb begin
		// a change must persist beyond the programmed count before it passes
		for (int i = 0; i < 3; i++) begin
			enc_f_d[i] = enc_f_q[i];
			flt_cnt_d[i] = 4'h0;
			if (enc_s[i] != enc_f_q[i]) begin
				if (flt_cnt_q[i] >= filt_set_q) begin
					enc_f_d[i] = enc_s[i];
				end else begin
					flt_cnt_d[i] = flt_cnt_q[i] + 4'h1;
				end
			end
		end
		moved = (enc_f_q[0] != enc_o_q[0]) | (enc_f_q[1] != enc_o_q[1]);
		enc_cnt_d = enc_cnt_q;
		if (moved) begin
			enc_cnt_d = (enc_f_q[0] ^ enc_o_q[1]) ? enc_cnt_q + 32'h1 : enc_cnt_q - 32'h1;
		end
		// compare only on a count change so one position gives one pulse
		bp_hit = bp_en_q & moved & (enc_cnt_d == bp_pos_q);
		// pulse length fixed at the rounded-up least width
		bp_cnt_d = bp_hit ? 3'(BP_PULSE_CYC) : (bp_cnt_q != 3'h0 ? bp_cnt_q - 3'h1 : 3'h0);
		// capture edge taken straight from the synchronised line
		cap_sel = cap_ctrl_q[CAP_SEL_LSB +: 3];
		cap_hit = cap_ctrl_q[CAP_EN_BIT] & tbus_s[cap_sel] & ~tbus_o_q[cap_sel];
		cap_pos_d = cap_hit ? enc_cnt_q : cap_pos_q;
		for (int i = 0; i < TBUS_W; i++) begin
			rt = route_q[ROUTE_W*i +: ROUTE_W];
			tbus_oe_d[i] = 1'b1;
			tbus_dr_d[i] = 1'b0;
			// per-line routing of breakpoint or encoder signals
			unique case (rt)
				// breakpoint drives high only for the pulse
				RT_BP: tbus_dr_d[i] = (bp_cnt_d != 3'h0);
				// encoder signals leave in filtered form, output only
				RT_ENC_A: tbus_dr_d[i] = enc_f_d[0];
				RT_ENC_B: tbus_dr_d[i] = enc_f_d[1];
				RT_INDEX: tbus_dr_d[i] = enc_f_d[2];
				default: begin
					tbus_oe_d[i] = tgpio_q[TBUS_DIR_LSB + i];
					tbus_dr_d[i] = tgpio_q[i];
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			enc_f_q <= 3'h0;
			enc_o_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				flt_cnt_q[i] <= 4'h0;
			end
			enc_cnt_q <= 32'h0;
			cap_pos_q <= 32'h0;
			bp_cnt_q <= 3'h0;
			tbus_o_q <= '0;
			tbus_dr_q <= '0;
			tbus_oe_q <= '0;
		end else if (ce_in) begin
			enc_f_q <= enc_f_d;
			enc_o_q <= enc_f_q;
			flt_cnt_q <= flt_cnt_d;
			enc_cnt_q <= enc_cnt_d;
			cap_pos_q <= cap_pos_d;
			bp_cnt_q <= bp_cnt_d;
			tbus_o_q <= tbus_s;
			tbus_dr_q <= tbus_dr_d;
			tbus_oe_q <= tbus_oe_d;
		end
	end

	// ----------------------------------------------------------------
	// digital ports and pwm
	// ----------------------------------------------------------------
	logic [31:0] gpio_q, gpio_oe_q;
	logic pclk_o_q;
	logic pwm_tick;

	// four byte ports share one 32-bit latch, sliced by address
	// outputs driven through polarity, enabled per line
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			gpio_q <= 32'h0;
			gpio_oe_q <= 32'h0;
			pclk_o_q <= 1'b0;
		end else if (ce_in) begin
			gpio_q <= port_out_d ^ pol_d;
			gpio_oe_q <= dir_d;
			pclk_o_q <= pclk_s;
		end
	end

	// external clock rising edge or every cycle of the internal clock
	// timebase chosen by software, paced by pwm_clk_in when external
	assign pwm_tick = pwm_ext_q ? (pclk_s & ~pclk_o_q) : 1'b1;

	mdio_pwm_gen u_pulse_output_one (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.tick_in(pwm_tick),
		.cfg_in(pulse_output_one_q),
		.pwm_out(pulse_output_one_out)
	);

	mdio_pwm_gen u_pulse_output_two (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.tick_in(pwm_tick),
		.cfg_in(pulse_output_two_q),
		.pwm_out(pulse_output_two_out)
	);

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rdata_out = rdata_q;
	assign gpio_out = gpio_q;
	assign gpio_oe_out = gpio_oe_q;
	// weak pull direction follows the caught strap
	assign pull_up_en_out = pull_up_q;
	assign pull_down_en_out = ~pull_up_q;
	assign shared_trigger_bus_out = tbus_dr_q;
	assign shared_trigger_bus_oe_out = tbus_oe_q;
endmodule

// [mdio_assertions.sv]
// concurrent checks on the digital i/o block ports
`timescale 1ns/1ns
module mdio_assertions #(
	parameter int unsigned TBUS_W = 8
)(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] gpio_oe_out,
	input wire logic pull_up_en_out,
	input wire logic pull_down_en_out,
	input wire logic [TBUS_W-1:0] shared_trigger_bus_out,
	input wire logic [TBUS_W-1:0] shared_trigger_bus_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	sequence s_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// line 1 is kept for breakpoints by the bench, so any rise there is a pulse
	sequence s_bp_pulse;
		(shared_trigger_bus_out[1] && shared_trigger_bus_oe_out[1]) [*5] ##1
			!shared_trigger_bus_out[1];
	endsequence
	chk_pull_pair: assert property (pull_down_en_out == !pull_up_en_out)
		else $error("pull enables not complementary");
	chk_reset_dirs: assert property (@(posedge clk_in) disable iff (1'b0)
		srst_in |=> gpio_oe_out == 32'h0000_0000 && !s_axi_bvalid_out && !s_axi_rvalid_out)
		else $error("outputs not cleared by reset");
	chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid_out)
		else $error("write response late");
	chk_ready_drop: assert property (s_wr_taken |=> !s_axi_awready_out && !s_axi_wready_out)
		else $error("ready stayed high after write taken");
	chk_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped early");
	chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data late");
	chk_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
		else $error("read data dropped early");
	chk_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address accepted while data pending");
	chk_bp_width: assert property ($rose(shared_trigger_bus_out[1]) |-> s_bp_pulse)
		else $error("breakpoint pulse width wrong");
endmodule

// [mdio_field_model.sv]
// field wiring model: resolves the pin levels seen by the block
`timescale 1ns/1ns
module mdio_field_model (
	input wire logic [31:0] gpio_out_in,
	input wire logic [31:0] gpio_oe_in,
	input wire logic pull_up_in,
	input wire logic [31:0] ext_val_in,
	input wire logic [31:0] ext_en_in,
	output logic [31:0] pin_out,
	input wire logic [7:0] tbus_out_in,
	input wire logic [7:0] tbus_oe_in,
	input wire logic [7:0] tbus_ext_in,
	output logic [7:0] tbus_pin_out
);
	// driven, externally driven or weakly pulled
	assign pin_out = (gpio_oe_in & gpio_out_in) | (~gpio_oe_in & ext_en_in & ext_val_in)
		| (~gpio_oe_in & ~ext_en_in & {32{pull_up_in}});
	// other boards drive every line the block leaves free
	assign tbus_pin_out = (tbus_oe_in & tbus_out_in) | (~tbus_oe_in & tbus_ext_in);
endmodule

// [tb_top.sv]
// self-checking bench for the digital i/o block
`timescale 1ns/1ns
module tb_top;
	import mdio_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, tb_ext = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, ext_val = 32'h0, ext_en = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, pull_up, pull_dn, p1, p2;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, gpio_pin, gpio_out, gpio_oe, d;
	logic [7:0] tb_in, tb_out, tb_oe;
	logic [2:0] pdiv = 3'h0;
	logic prun = 1'b0, ea = 1'b0, eb = 1'b0, ei = 1'b0, strap = 1'b1;
	int mismatches = 0, n_compared = 0, cyc = 0, h1, h2, hb, h3;
	always #10 clk_in = ~clk_in;
	// pdiv[2] is the external pwm clock, one tick per 8 cycles
	always @(posedge clk_in) begin
		if (prun) pdiv <= pdiv + 3'h1;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	mdio_top uut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .gpio_in(gpio_pin),
		.gpio_out(gpio_out), .gpio_oe_out(gpio_oe), .pull_select_strap_in(strap),
		.pull_up_en_out(pull_up), .pull_down_en_out(pull_dn), .pwm_clk_in(pdiv[2]),
		.pulse_output_one_out(p1), .pulse_output_two_out(p2), .enc_a_in(ea), .enc_b_in(eb),
		.enc_index_in(ei), .shared_trigger_bus_in(tb_in), .shared_trigger_bus_out(tb_out),
		.shared_trigger_bus_oe_out(tb_oe));
	mdio_field_model u_field (.gpio_out_in(gpio_out), .gpio_oe_in(gpio_oe), .pull_up_in(pull_up),
		.ext_val_in(ext_val), .ext_en_in(ext_en), .pin_out(gpio_pin), .tbus_out_in(tb_out),
		.tbus_oe_in(tb_oe), .tbus_ext_in(tb_ext), .tbus_pin_out(tb_in));
	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// counts high cycles of the pwm outputs and two routed bus lines
	task automatic run(int n);
		repeat (n) begin
			@(posedge clk_in);
			h1 += (p1 === 1'b1);
			h2 += (p2 === 1'b1);
			hb += (tb_out[1] === 1'b1);
			h3 += (tb_out[3] === 1'b1);
		end
	endtask
	task automatic clr();
		h1 = 0;
		h2 = 0;
		hb = 0;
		h3 = 0;
	endtask
	task automatic enc(logic a, logic b);
		ea <= a;
		eb <= b;
		run(12);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		srst_in <= 1'b0;
		clr();
		rd(OFF_DIR);
		chk("dir", d, DIR_RST);
		rd(OFF_POL);
		chk("pol", d, POL_RST);
		rd(OFF_STRAP);
		chk("strap", d, 32'h1);
		chk("pull_up", {31'h0, pull_up}, 32'h1);
		chk("oe_rst", gpio_oe, 32'h0);
		rd(OFF_PORT3);
		chk("port3_pull", d, 32'hff);
		wr(OFF_DIR, 32'h0000_00ff);
		wr(OFF_PORT0, 32'hffff_ff5a);
		chk("out0", gpio_out, 32'h0000_005a);
		chk("oe0", gpio_oe, 32'h0000_00ff);
		rd(OFF_PORT0);
		chk("port0", d, 32'h5a);
		ext_en <= 32'h0000_ff00;
		ext_val <= 32'h0000_3c00;
		wr(OFF_POL, 32'h0000_ff00);
		run(4);
		rd(OFF_PORT1);
		chk("port1_in", d, 32'hc3);
		ext_en <= 32'h0;
		wr(OFF_DIR, 32'h0000_ffff);
		wr(OFF_PORT1, 32'h0f);
		chk("out1", {24'h0, gpio_out[15:8]}, 32'hf0);
		rd(8'hfc);
		chk("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(OFF_PULSE_OUTPUT_ONE, 32'h0003_000a);
		wr(OFF_PULSE_OUTPUT_TWO, 32'h0008_0008);
		run(4);
		clr();
		run(20);
		chk("pulse_output_one_int", 32'(h1), 32'd6);
		chk("pulse_output_two_full", 32'(h2), 32'd20);
		wr(OFF_PWM_CTRL, 32'h1);
		run(4);
		clr();
		run(30);
		chk("pulse_output_one_still", 32'(h1 % 30), 32'd0);
		prun <= 1'b1;
		run(16);
		clr();
		run(80);
		chk("pulse_output_one_ext", 32'(h1), 32'd24);
		tb_ext <= 8'h04;
		wr(OFF_TBUS_GPIO, 32'h0000_0101);
		run(4);
		chk("tbus_drv", {30'h0, tb_oe[0], tb_out[0]}, 32'h3);
		rd(OFF_TBUS_IN);
		chk("tbus_in", d, 32'h05);
		tb_ext <= 8'h00;
		wr(OFF_TBUS_ROUTE, 32'h0000_0408);
		wr(OFF_BP_POS, 32'h2);
		wr(OFF_BP_CTRL, 32'h1);
		run(2);
		chk("route_oe", {30'h0, tb_oe[3], tb_oe[1]}, 32'h3);
		clr();
		enc(1'b1, 1'b0);
		enc(1'b1, 1'b1);
		enc(1'b0, 1'b1);
		enc(1'b0, 1'b0);
		chk("bp_pulse", 32'(hb), 32'd5);
		rd(OFF_ENC_COUNT);
		chk("count", d, 32'd4);
		wr(OFF_FILT, 32'h3);
		clr();
		ea <= 1'b1;
		run(2);
		enc(1'b0, 1'b0);
		chk("glitch", 32'(h3), 32'd0);
		enc(1'b1, 1'b0);
		chk("enc_a_out", {31'h0, tb_out[3]}, 32'h1);
		wr(OFF_CAP_CTRL, 32'h5);
		tb_ext <= 8'h04;
		run(8);
		rd(OFF_CAP_POS);
		chk("cap_pos", d, 32'd5);
		rd(OFF_STATUS);
		chk("status", d, 32'h3);
		wr(OFF_STATUS, 32'h3);
		rd(OFF_STATUS);
		chk("status_clr", d, 32'h0);
		wr(OFF_TBUS_ROUTE, 32'h0000_3800);
		run(2);
		chk("enc_b_idx_lo", {30'h0, tb_out[4], tb_out[3]}, 32'h0);
		eb <= 1'b1;
		ei <= 1'b1;
		run(12);
		chk("enc_b_idx_hi", {30'h0, tb_out[4], tb_out[3]}, 32'h3);
		strap <= 1'b0;
		srst_in <= 1'b1;
		run(4);
		srst_in <= 1'b0;
		rd(OFF_STRAP);
		chk("strap_low", d, 32'h0);
		chk("pull_dn", {31'h0, pull_dn}, 32'h1);
		rd(OFF_PORT2);
		chk("port2_pull", d, 32'h0);
		tally_and_finish();
	end
endmodule
bind mdio_top mdio_assertions #(.TBUS_W(TBUS_W)) u_chk (.clk_in(clk_in), .srst_in(srst_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.gpio_oe_out(gpio_oe_out), .pull_up_en_out(pull_up_en_out),
	.pull_down_en_out(pull_down_en_out), .shared_trigger_bus_out(shared_trigger_bus_out),
	.shared_trigger_bus_oe_out(shared_trigger_bus_oe_out));
